// File: bench/lba_loop_model.sv
`timescale 1ns/1ns
module lba_loop_model (
  // clock
  input wire logic          pclk,
  // loop and tuning
  output lba_pkg::loop_in_s loop_in,
  output lba_pkg::tune_s    tune
);
  import lba_pkg::*;
  initial begin
    loop_in = '0;
    tune = '0;
  end
  // f packs max, min, memory error, converter error
  task drive(input logic [15:0] pv, input logic [3:0] f);
    @(posedge pclk);
    loop_in <= {pv, f};
  endtask : drive
  task tun(input logic [15:0] t);
    @(posedge pclk);
    tune <= {1'b1, t};
    @(posedge pclk);
    tune <= '0;
  endtask : tun
endmodule : lba_loop_model

// File: bench/lba_props.sv
`timescale 1ns/1ns
module lba_props
  import lba_pkg::*;
#(parameter int TICK_CYC = 10) (
  // clock and reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  // apb
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic [lba_pkg::DATA_W-1:0] prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // loop
  input wire lba_pkg::loop_in_s          loop_in,
  input wire logic                       loop_break_alarm
);
  // counts from saturation start, never below the design's own restart point
  int  sat_cnt_r;
  int  sat_cnt_nxt;
  wire sat = (loop_in.mv_at_max | loop_in.mv_at_min) & ~loop_in.memory_error & ~loop_in.adc_error;
  always_comb sat_cnt_nxt = sat ? sat_cnt_r + 1 : 0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sat_cnt_r <= 0;
    else sat_cnt_r <= sat_cnt_nxt;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_ready_latency: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == '0) else $error("prdata not zero");
  a_mem_err_quiet: assert property (loop_in.memory_error |-> ##2 !loop_break_alarm)
    else $error("alarm during memory error");
  a_adc_err_quiet: assert property (loop_in.adc_error |-> ##2 !loop_break_alarm)
    else $error("alarm during converter error");
  a_unsat_quiet: assert property (!loop_in.mv_at_max && !loop_in.mv_at_min |-> ##2 !loop_break_alarm)
    else $error("alarm without saturation");
  a_no_early_judge: assert property ($rose(loop_break_alarm) |-> sat_cnt_r >= TICK_CYC)
    else $error("alarm before one interval");
  a_alarm_holds: assert property ($rose(loop_break_alarm) && sat && $stable(loop_in.mv_at_max)
    && $stable(loop_in.mv_at_min) |=> loop_break_alarm) else $error("alarm dropped early");
  c_alarm: cover property ($rose(loop_break_alarm));
  c_slverr: cover property (pslverr);
  c_min_alarm: cover property (loop_in.mv_at_min && loop_break_alarm);
endmodule : lba_props
bind loop_break_alarm_monitor lba_props #(.TICK_CYC(TICK_CYC)) i_lba_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .loop_in(loop_in),
  .loop_break_alarm(loop_break_alarm));

// File: bench/loop_break_alarm_monitor_tb.sv
`timescale 1ns/1ns
module loop_break_alarm_monitor_tb;
  import lba_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, q;
  logic pready, pslverr, loop_break_alarm, e;
  loop_in_s loop_in;
  tune_s tune;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  always #5 pclk = ~pclk;
  lba_loop_model i_lba_loop_model (.pclk(pclk), .loop_in(loop_in), .tune(tune));
  loop_break_alarm_monitor #(.TICK_CYC(10)) i_loop_break_alarm_monitor (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .loop_in(loop_in), .tune(tune),
    .loop_break_alarm(loop_break_alarm));
  task complete_run;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run;
    end
  end
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task rd(input logic [11:0] a, input logic [31:0] x, input string n);
    apb(0, a, '0);
    chk(n, x, q);
  endtask : rd
  // judgment every 20 cycles; samples sit mid-interval to absorb latency
  task step(input logic [15:0] pv, input logic [3:0] f, input int n, input logic x);
    i_lba_loop_model.drive(pv, f);
    repeat (n) @(posedge pclk);
    #1 chk("alarm", {31'h0, x}, {31'h0, loop_break_alarm});
  endtask : step
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    rd(OFS_CTRL, 0, "ctrl");
    rd(OFS_DET_TIME, 0, "det_time");
    rd(OFS_FULL_SCALE, 32'h2710, "full_scale");
    rd(OFS_DET_WIDTH, 32'h14, "det_width");
    rd(12'h020, 0, "unmapped");
    chk("slverr", 1, {31'h0, e});
    apb(1, OFS_DET_TIME, 2);
    apb(1, OFS_DET_WIDTH, 32'hA);
    rd(OFS_DET_WIDTH, 32'hA, "det_width_wr");
    apb(1, OFS_CTRL, 1);
    step(1000, 8, 29, 1);
    step(1010, 8, 20, 1);
    step(1021, 8, 20, 0);
    step(1000, 8, 20, 1);
    rd(OFS_STATUS, 7, "status");
    step(1000, 0, 2, 0);
    step(1000, 4, 29, 1);
    step(1050, 4, 20, 1);
    step(989, 4, 20, 0);
    step(989, 6, 45, 0);
    step(989, 4, 29, 1);
    step(989, 5, 45, 0);
    apb(1, OFS_CTRL, 0);
    step(989, 4, 45, 0);
    i_lba_loop_model.tun(5);
    rd(OFS_DET_TIME, 5, "tuned");
    apb(1, OFS_CTRL, 2);
    i_lba_loop_model.tun(7);
    rd(OFS_DET_TIME, 5, "heatcool_tuned");
    complete_run;
  end
endmodule : loop_break_alarm_monitor_tb

// File: hw/lba_interval_timer.sv
`timescale 1ns/1ns
module lba_interval_timer #(
  parameter int PRE = 100000000
) (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // control
  input  wire logic                       restart,
  input  wire logic [lba_pkg::TIME_W-1:0] length,
  // result
  output logic                            expire
);
  import lba_pkg::*;

  logic [PRE_W-1:0]  pre_r,  pre_nxt;
  logic [TIME_W-1:0] sec_r,  sec_nxt;
  logic              exp_nxt;
  logic              tick;

  always_comb begin
    tick    = (pre_r == PRE_W'(PRE - 1));
    pre_nxt = tick ? '0 : pre_r + PRE_W'(1);
    sec_nxt = sec_r;
    exp_nxt = 1'b0;
    if (restart) begin
      pre_nxt = '0;
      sec_nxt = '0;
    end else if (tick) begin
      // zero length means never judge
      if (length != '0 && sec_r + TIME_W'(1) >= length) begin
        sec_nxt = '0;
        exp_nxt = 1'b1;
      end else begin
        sec_nxt = sec_r + TIME_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r  <= '0;
      sec_r  <= '0;
      expire <= 1'b0;
    end else begin
      pre_r  <= pre_nxt;
      sec_r  <= sec_nxt;
      expire <= exp_nxt;
    end
  end
endmodule : lba_interval_timer

// File: hw/lba_pkg.sv
package lba_pkg;
  localparam int PV_W             = 16;
  localparam int TIME_W           = 16;
  localparam int PRE_W            = 32;
  localparam int DATA_W           = 32;
  localparam int ADDR_W           = 12;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL       = 12'h000;
  localparam logic [11:0] OFS_DET_TIME   = 12'h004;
  localparam logic [11:0] OFS_DET_WIDTH  = 12'h008;
  localparam logic [11:0] OFS_STATUS     = 12'h00C;
  localparam logic [11:0] OFS_FULL_SCALE = 12'h010;
  // ctrl fields
  localparam int CTRL_ASSIGNED_BIT = 0;
  localparam int CTRL_HEATCOOL_BIT = 1;
  // status fields
  localparam int ST_ALARM_BIT  = 0;
  localparam int ST_ACTIVE_BIT = 1;
  localparam int ST_SAT_BIT    = 2;
  // reset values
  localparam logic [15:0] DET_TIME_RST   = 16'h0000;
  localparam logic [15:0] FULL_SCALE_RST = 16'h2710;
  // 0.2 percent of full scale is fs/500
  localparam logic [15:0] WIDTH_DIV      = 16'h01F4;
  // detection time counts in seconds
  localparam int TICK_NS          = 1000000000;
  localparam int CLK_NS           = 10;
  localparam int TICK_CYCLES      = TICK_NS / CLK_NS;

  typedef enum logic [1:0] {SAT_NONE, SAT_MAX, SAT_MIN} sat_e;

  typedef struct packed {
    logic [PV_W-1:0] process_value;
    logic            mv_at_max;
    logic            mv_at_min;
    logic            memory_error;
    logic            adc_error;
  } loop_in_s;

  typedef struct packed {
    logic              valid;
    logic [TIME_W-1:0] det_time;
  } tune_s;
endpackage : lba_pkg

// File: hw/loop_break_alarm_monitor.sv
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ns
// Contract
// - monitor runs only when the alarm is assigned to an output
// - memory or converter error suppresses evaluation
// - at saturation, alarm if value has not moved as expected after interval
// - judge at end of every interval counted from saturation start
// - movement below detection width counts as no change
// - movement above width in expected direction keeps alarm off
// - movement opposite to expected direction raises alarm at judgment
// - detection width configurable, default 0.2 percent of full scale
// - auto-tuning loads detection time, except in heating and cooling
module loop_break_alarm_monitor #(
  parameter int TICK_CYC = lba_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [lba_pkg::ADDR_W-1:0] paddr,
  input  wire logic [lba_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic [lba_pkg::DATA_W-1:0]      prdata,
  output logic                            pready,
  output logic                            pslverr,
  // control loop
  input  wire lba_pkg::loop_in_s          loop_in,
  input  wire lba_pkg::tune_s             tune,
  // alarm
  output logic                            loop_break_alarm
);
  import lba_pkg::*;

  logic [15:0]       ctrl_r,  ctrl_nxt;
  logic [TIME_W-1:0] time_r,  time_nxt;
  logic [PV_W-1:0]   width_r, width_nxt;
  logic [PV_W-1:0]   fs_r,    fs_nxt;
  logic              wdef_r,  wdef_nxt;
  logic [DATA_W-1:0] rdata_nxt;
  logic              rdy_nxt, err_nxt;
  logic              wr_acc,  rd_acc, hit;
  logic [PV_W-1:0]   width_eff;
  // monitor core state, declared ahead of the status read path
  sat_e              sat_r,   sat_nxt;
  logic [PV_W-1:0]   ref_r,   ref_nxt;
  logic              alarm_nxt;
  logic              active,  restart, judge;
  logic [PV_W:0]     delta;
  logic              moved_ok;
  sat_e              sat_now;

  // single wait state: pready rises after the first access edge
  // writes land only on the edge where pready is seen high
  always_comb begin
    wr_acc    = psel && penable && pready && pwrite;
    rd_acc    = psel && penable && !pready && !pwrite;
    ctrl_nxt  = ctrl_r;
    time_nxt  = time_r;
    width_nxt = width_r;
    fs_nxt    = fs_r;
    wdef_nxt  = wdef_r;
    rdata_nxt = '0;
    rdy_nxt   = psel && penable && !pready;
    hit       = 1'b1;
    case (paddr)
      OFS_CTRL: begin
        if (wr_acc && pstrb[0]) ctrl_nxt = {14'h0000, pwdata[1:0]};
        rdata_nxt = {16'h0000, ctrl_r};
      end
      OFS_DET_TIME: begin
        if (wr_acc && pstrb[1:0] == 2'h3) time_nxt = pwdata[15:0];
        rdata_nxt = {16'h0000, time_r};
      end
      OFS_DET_WIDTH: begin
        if (wr_acc && pstrb[1:0] == 2'h3) begin
          width_nxt = pwdata[15:0];
          wdef_nxt  = 1'b0;
        end
        rdata_nxt = {16'h0000, width_eff};
      end
      OFS_STATUS: begin
        rdata_nxt = {29'h00000000, sat_r != SAT_NONE, active, loop_break_alarm};
      end
      OFS_FULL_SCALE: begin
        if (wr_acc && pstrb[1:0] == 2'h3) fs_nxt = pwdata[15:0];
        rdata_nxt = {16'h0000, fs_r};
      end
      default: hit = 1'b0;
    endcase
    err_nxt = rdy_nxt && !hit;
    if (!rd_acc) rdata_nxt = '0;
    // tuning result wins over a software write in the same cycle
    if (tune.valid && !ctrl_r[CTRL_HEATCOOL_BIT]) time_nxt = tune.det_time;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= '0;
      time_r  <= DET_TIME_RST;
      width_r <= '0;
      fs_r    <= FULL_SCALE_RST;
      wdef_r  <= 1'b1;
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      time_r  <= time_nxt;
      width_r <= width_nxt;
      fs_r    <= fs_nxt;
      wdef_r  <= wdef_nxt;
      prdata  <= rdata_nxt;
      pready  <= rdy_nxt;
      pslverr <= err_nxt;
    end
  end

  // default width tracks full scale until software writes one
  assign width_eff = wdef_r ? fs_r / WIDTH_DIV : width_r;

  // monitor core
  lba_interval_timer #(
    .PRE (TICK_CYC)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (restart),
    .length  (time_r),
    .expire  (judge)
  );

  always_comb begin
    active = ctrl_r[CTRL_ASSIGNED_BIT]
             && !loop_in.memory_error && !loop_in.adc_error;
    if (loop_in.mv_at_max)      sat_now = SAT_MAX;
    else if (loop_in.mv_at_min) sat_now = SAT_MIN;
    else                        sat_now = SAT_NONE;
    // new saturation or leaving it restarts counting
    restart = !active || sat_now != sat_r;
    // signed movement in expected direction
    if (sat_r == SAT_MAX) delta = {1'b0, loop_in.process_value} - {1'b0, ref_r};
    else                  delta = {1'b0, ref_r} - {1'b0, loop_in.process_value};
    // negative or under-width movement is no change
    moved_ok  = !delta[PV_W] && delta[PV_W-1:0] > width_eff;
    sat_nxt   = active ? sat_now : SAT_NONE;
    ref_nxt   = ref_r;
    alarm_nxt = loop_break_alarm;
    if (restart) begin
      ref_nxt   = loop_in.process_value;
      alarm_nxt = 1'b0;
    end else if (judge && sat_r != SAT_NONE) begin
      alarm_nxt = !moved_ok;
      ref_nxt   = loop_in.process_value;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sat_r            <= SAT_NONE;
      ref_r            <= '0;
      loop_break_alarm <= 1'b0;
    end else begin
      sat_r            <= sat_nxt;
      ref_r            <= ref_nxt;
      loop_break_alarm <= alarm_nxt;
    end
  end
endmodule : loop_break_alarm_monitor
